// file: src/cpu_instruction_length_timing.sv
`timescale 1ns/1ps

module cpu_instruction_length_timing
#(
  parameter int CYCLE_W = 3
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // Instruction form request
  input wire logic formValid,
  input wire cpu_timing_pkg::instr_form_t formCode,
  input wire logic extTarget,
  // Operand values
  input wire logic [7:0] accumulator,
  input wire logic [15:0] dataPointer,
  input wire logic [15:0] progCounter,
  // Sequencing status
  output logic formReady,
  output logic busy,
  output logic instrDone,
  output logic [CYCLE_W-1:0] stepIndex,
  output logic [1:0] instrLength,
  output logic [CYCLE_W-1:0] cycleCount,
  output logic unsupportedFault,
  // Memory strobes
  output logic codeReadEn,
  output logic [15:0] codeReadAddr,
  output logic auxReadEn,
  output logic auxWriteEn,
  output logic auxAddrWide,
  output logic stackPush,
  output logic stackPop,
  output logic accumWriteEn,
  output logic dataWriteEn
);

  cpu_timing_pkg::seq_state_t state_reg;
  cpu_timing_pkg::seq_state_t state_next;
  logic busy_reg;

  logic [1:0] decLen;
  logic [2:0] decCycles;
  logic decLegal;
  logic decWrAccum;
  logic decWrData;
  logic decCodeRd;
  logic decPcBase;
  logic decAuxRd;
  logic decAuxWr;
  logic decAuxWide;
  logic decPush;
  logic decPop;

  logic ready_reg;
  logic done_reg;
  logic fault_reg;
  logic [CYCLE_W-1:0] count_reg;
  logic [CYCLE_W-1:0] count_next;
  logic [CYCLE_W-1:0] step_reg;
  logic [CYCLE_W-1:0] step_next;
  logic [CYCLE_W-1:0] total_reg;
  logic [1:0] len_reg;

  logic attrWrAccum_reg;
  logic attrWrData_reg;
  logic attrCodeRd_reg;
  logic attrAuxRd_reg;
  logic attrAuxWr_reg;
  logic attrPush_reg;
  logic attrPop_reg;
  logic auxWide_reg;

  logic codeRd_reg;
  logic [15:0] codeAddr_reg;
  logic auxRd_reg;
  logic auxWr_reg;
  logic push_reg;
  logic pop_reg;
  logic accumWr_reg;
  logic dataWr_reg;

  function automatic logic [15:0] codeAddress(input logic [7:0] offset,
                                              input logic [15:0] base);
    codeAddress = base + {8'h00, offset};
  endfunction

  function automatic logic [CYCLE_W-1:0] widen(input logic [2:0] v);
    widen = CYCLE_W'(v);
  endfunction

  instr_form_decode formDecode
  (
    .form(formCode),
    .lenBytes(decLen),
    .cycles(decCycles),
    .legal(decLegal),
    .wrAccum(decWrAccum),
    .wrData(decWrData),
    .codeRd(decCodeRd),
    .pcBase(decPcBase),
    .auxRd(decAuxRd),
    .auxWr(decAuxWr),
    .auxWide(decAuxWide),
    .pushOp(decPush),
    .popOp(decPop)
  );

  // Acceptance and refusal
  wire execActive = (state_reg == cpu_timing_pkg::SEQ_EXEC);
  wire accept = formValid & ready_reg;
  wire extBlocked = extTarget & (decAuxRd | decAuxWr);
  wire start = accept & decLegal & ~extBlocked;
  wire reject = accept & ~start;
  wire lastCycle = execActive & (count_reg == '0);
  wire oneCycle = (decCycles == 3'h1);

  assign count_next = start ? widen(decCycles - 3'h1) :
                      (execActive & ~lastCycle) ?
                      count_reg - CYCLE_W'(1) : count_reg;

  assign step_next = start ? '0 :
                     (execActive & ~lastCycle) ?
                     step_reg + CYCLE_W'(1) : step_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      cpu_timing_pkg::SEQ_IDLE:
        if (start)
          state_next = cpu_timing_pkg::SEQ_EXEC;
      cpu_timing_pkg::SEQ_EXEC:
        if (lastCycle & ~start)
          state_next = cpu_timing_pkg::SEQ_IDLE;
      default:
        state_next = cpu_timing_pkg::SEQ_IDLE;
    endcase
  end

  // Next-cycle view for the strobes
  wire busyNext = (state_next == cpu_timing_pkg::SEQ_EXEC);
  wire lastNext = busyNext & (count_next == '0);
  wire penultNext = busyNext & (count_next == CYCLE_W'(1));
  wire firstNext = busyNext & (step_next == '0);

  wire nWrAccum = start ? decWrAccum : attrWrAccum_reg;
  wire nWrData = start ? decWrData : attrWrData_reg;
  wire nCodeRd = start ? decCodeRd : attrCodeRd_reg;
  wire nAuxRd = start ? decAuxRd : attrAuxRd_reg;
  wire nAuxWr = start ? decAuxWr : attrAuxWr_reg;
  wire nPush = start ? decPush : attrPush_reg;
  wire nPop = start ? decPop : attrPop_reg;

  // Ready again only in the last cycle
  wire readyNext = start ? oneCycle :
                   execActive ? (count_reg <= CYCLE_W'(1)) : 1'b1;
  wire doneNext = start ? oneCycle :
                  (execActive & (count_reg == CYCLE_W'(1)));

  // Sequencer state; busy kept as its own flop, not a decode
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= cpu_timing_pkg::SEQ_IDLE;
      busy_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      state_reg <= state_next;
      busy_reg <= busyNext;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count_reg <= '0;
      step_reg <= '0;
    end
    else if (clkEn)
    begin
      count_reg <= count_next;
      step_reg <= step_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      ready_reg <= readyNext;
      done_reg <= doneNext;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      fault_reg <= 1'b0;
    else if (clkEn)
      fault_reg <= reject;
  end

  // Length and cycles latched per form
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      len_reg <= 2'h0;
      total_reg <= '0;
    end
    else if (clkEn & start)
    begin
      len_reg <= decLen;
      total_reg <= widen(decCycles);
    end
  end

  // Attributes held for the whole instruction
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      attrWrAccum_reg <= 1'b0;
      attrWrData_reg <= 1'b0;
      attrCodeRd_reg <= 1'b0;
      attrAuxRd_reg <= 1'b0;
      attrAuxWr_reg <= 1'b0;
      attrPush_reg <= 1'b0;
      attrPop_reg <= 1'b0;
    end
    else if (clkEn & start)
    begin
      attrWrAccum_reg <= decWrAccum;
      attrWrData_reg <= decWrData;
      attrCodeRd_reg <= decCodeRd;
      attrAuxRd_reg <= decAuxRd;
      attrAuxWr_reg <= decAuxWr;
      attrPush_reg <= decPush;
      attrPop_reg <= decPop;
    end
  end

  // Code address from accumulator plus base
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      codeAddr_reg <= 16'h0000;
    else if (clkEn & start & decCodeRd)
      codeAddr_reg <= codeAddress(accumulator,
                                  decPcBase ? progCounter : dataPointer);
  end

  // Address width held with the move
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      auxWide_reg <= 1'b0;
    else if (clkEn & start)
      auxWide_reg <= decAuxWide;
  end

  // Memory reads sit in the cycle before the result lands
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      codeRd_reg <= 1'b0;
      auxRd_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      codeRd_reg <= nCodeRd & penultNext;
      auxRd_reg <= nAuxRd & penultNext;
    end
  end

  // Auxiliary write in the final cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      auxWr_reg <= 1'b0;
    else if (clkEn)
      auxWr_reg <= nAuxWr & lastNext;
  end

  // Push writes the stack at the end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      push_reg <= 1'b0;
    else if (clkEn)
      push_reg <= nPush & lastNext;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pop_reg <= 1'b0;
    else if (clkEn)
      pop_reg <= nPop & firstNext;
  end

  // Results commit only in the last cycle, so a refused
  // or overlapping form never disturbs state early
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      accumWr_reg <= 1'b0;
      dataWr_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      accumWr_reg <= nWrAccum & lastNext;
      dataWr_reg <= nWrData & lastNext;
    end
  end

  // Outputs straight from flip-flops
  assign formReady = ready_reg;
  assign busy = busy_reg;
  assign instrDone = done_reg;
  assign stepIndex = step_reg;
  assign instrLength = len_reg;
  assign cycleCount = total_reg;
  assign unsupportedFault = fault_reg;
  assign codeReadEn = codeRd_reg;
  assign codeReadAddr = codeAddr_reg;
  assign auxReadEn = auxRd_reg;
  assign auxWriteEn = auxWr_reg;
  assign auxAddrWide = auxWide_reg;
  assign stackPush = push_reg;
  assign stackPop = pop_reg;
  assign accumWriteEn = accumWr_reg;
  assign dataWriteEn = dataWr_reg;

endmodule

// file: src/cpu_timing_regs.svh
`ifndef CPU_TIMING_REGS_SVH
`define CPU_TIMING_REGS_SVH

// Timing word layout: length in bytes above, execution cycles below
`define TM_LEN_MSB 4
`define TM_LEN_LSB 3
`define TM_CYC_MSB 2
`define TM_CYC_LSB 0
`define TM_NONE 5'h00

// Data transfer
`define TM_ACCUM_FROM_BANK {2'd1, 3'd1}
`define TM_ACCUM_FROM_DIR {2'd2, 3'd2}
`define TM_ACCUM_FROM_IND {2'd1, 3'd2}
`define TM_ACCUM_FROM_IMM {2'd2, 3'd2}
`define TM_BANK_FROM_ACCUM {2'd1, 3'd2}
`define TM_BANK_FROM_DIR {2'd2, 3'd4}
`define TM_BANK_FROM_IMM {2'd2, 3'd2}
`define TM_DIR_FROM_ACCUM {2'd2, 3'd3}
`define TM_DIR_FROM_BANK {2'd2, 3'd3}
`define TM_DIR_FROM_DIR {2'd3, 3'd4}
`define TM_DIR_FROM_IND {2'd2, 3'd4}
`define TM_DIR_FROM_IMM {2'd3, 3'd3}
`define TM_IND_FROM_ACCUM {2'd1, 3'd3}
`define TM_IND_FROM_DIR {2'd2, 3'd3}
`define TM_IND_FROM_IMM {2'd2, 3'd3}
`define TM_DP_LOAD_IMM {2'd3, 3'd3}
`define TM_CODE_RD {2'd1, 3'd4}
`define TM_AUX_MOVE {2'd1, 3'd3}
`define TM_STACK_PUSH {2'd2, 3'd4}
`define TM_STACK_POP {2'd2, 3'd3}
`define TM_SWAP_BANK {2'd1, 3'd3}
`define TM_SWAP_DIR {2'd2, 3'd4}
`define TM_SWAP_IND {2'd1, 3'd4}
`define TM_NIB_SWAP_IND {2'd1, 3'd4}

// Arithmetic; add timings shared by add and add with carry, subtract with borrow on its own
`define TM_ADD_BANK {2'd1, 3'd2}
`define TM_ADD_DIR {2'd2, 3'd3}
`define TM_ADD_IND {2'd1, 3'd3}
`define TM_ADD_IMM {2'd2, 3'd2}
`define TM_SUB_BORROW_BANK {2'd1, 3'd2}

`endif

// file: src/cpu_timing_pkg.sv
package cpu_timing_pkg;

  typedef enum logic [5:0] {
    FORM_NONE,
    ACCUM_FROM_BANK, ACCUM_FROM_DIR, ACCUM_FROM_IND, ACCUM_FROM_IMM,
    BANK_FROM_ACCUM, BANK_FROM_DIR, BANK_FROM_IMM,
    DIR_FROM_ACCUM, DIR_FROM_BANK, DIR_FROM_DIR, DIR_FROM_IND,
    DIR_FROM_IMM,
    IND_FROM_ACCUM, IND_FROM_DIR, IND_FROM_IMM,
    DP_LOAD_IMM, CODE_RD_DP, CODE_RD_PC,
    AUX_RD_IND, AUX_RD_DP, AUX_WR_IND, AUX_WR_DP,
    STACK_PUSH, STACK_POP,
    SWAP_BANK, SWAP_DIR, SWAP_IND, NIB_SWAP_IND,
    ADD_BANK, ADD_DIR, ADD_IND, ADD_IMM,
    ADD_CARRY_BANK, ADD_CARRY_DIR, ADD_CARRY_IND, ADD_CARRY_IMM,
    SUB_BORROW_BANK
  } instr_form_t;

  typedef enum {
    SEQ_IDLE,
    SEQ_EXEC
  } seq_state_t;

endpackage

// file: src/instr_form_decode.sv
`timescale 1ns/1ps
`include "cpu_timing_regs.svh"

module instr_form_decode
(
  // Form to decode
  input wire cpu_timing_pkg::instr_form_t form,
  // Timing
  output logic [1:0] lenBytes,
  output logic [2:0] cycles,
  output logic legal,
  // Attributes
  output logic wrAccum,
  output logic wrData,
  output logic codeRd,
  output logic pcBase,
  output logic auxRd,
  output logic auxWr,
  output logic auxWide,
  output logic pushOp,
  output logic popOp
);

  logic [4:0] timing;

  always_comb
  begin
    timing = `TM_NONE;
    case (form)
      cpu_timing_pkg::ACCUM_FROM_BANK: timing = `TM_ACCUM_FROM_BANK;
      cpu_timing_pkg::ACCUM_FROM_DIR: timing = `TM_ACCUM_FROM_DIR;
      cpu_timing_pkg::ACCUM_FROM_IND: timing = `TM_ACCUM_FROM_IND;
      cpu_timing_pkg::ACCUM_FROM_IMM: timing = `TM_ACCUM_FROM_IMM;
      cpu_timing_pkg::BANK_FROM_ACCUM: timing = `TM_BANK_FROM_ACCUM;
      cpu_timing_pkg::BANK_FROM_DIR: timing = `TM_BANK_FROM_DIR;
      cpu_timing_pkg::BANK_FROM_IMM: timing = `TM_BANK_FROM_IMM;
      cpu_timing_pkg::DIR_FROM_ACCUM: timing = `TM_DIR_FROM_ACCUM;
      cpu_timing_pkg::DIR_FROM_BANK: timing = `TM_DIR_FROM_BANK;
      cpu_timing_pkg::DIR_FROM_DIR: timing = `TM_DIR_FROM_DIR;
      cpu_timing_pkg::DIR_FROM_IND: timing = `TM_DIR_FROM_IND;
      cpu_timing_pkg::DIR_FROM_IMM: timing = `TM_DIR_FROM_IMM;
      cpu_timing_pkg::IND_FROM_ACCUM: timing = `TM_IND_FROM_ACCUM;
      cpu_timing_pkg::IND_FROM_DIR: timing = `TM_IND_FROM_DIR;
      cpu_timing_pkg::IND_FROM_IMM: timing = `TM_IND_FROM_IMM;
      cpu_timing_pkg::DP_LOAD_IMM: timing = `TM_DP_LOAD_IMM;
      cpu_timing_pkg::CODE_RD_DP: timing = `TM_CODE_RD;
      cpu_timing_pkg::CODE_RD_PC: timing = `TM_CODE_RD;
      cpu_timing_pkg::AUX_RD_IND: timing = `TM_AUX_MOVE;
      cpu_timing_pkg::AUX_RD_DP: timing = `TM_AUX_MOVE;
      cpu_timing_pkg::AUX_WR_IND: timing = `TM_AUX_MOVE;
      cpu_timing_pkg::AUX_WR_DP: timing = `TM_AUX_MOVE;
      cpu_timing_pkg::STACK_PUSH: timing = `TM_STACK_PUSH;
      cpu_timing_pkg::STACK_POP: timing = `TM_STACK_POP;
      cpu_timing_pkg::SWAP_BANK: timing = `TM_SWAP_BANK;
      cpu_timing_pkg::SWAP_DIR: timing = `TM_SWAP_DIR;
      cpu_timing_pkg::SWAP_IND: timing = `TM_SWAP_IND;
      cpu_timing_pkg::NIB_SWAP_IND: timing = `TM_NIB_SWAP_IND;
      cpu_timing_pkg::ADD_BANK: timing = `TM_ADD_BANK;
      cpu_timing_pkg::ADD_DIR: timing = `TM_ADD_DIR;
      cpu_timing_pkg::ADD_IND: timing = `TM_ADD_IND;
      cpu_timing_pkg::ADD_IMM: timing = `TM_ADD_IMM;
      cpu_timing_pkg::ADD_CARRY_BANK: timing = `TM_ADD_BANK;
      cpu_timing_pkg::ADD_CARRY_DIR: timing = `TM_ADD_DIR;
      cpu_timing_pkg::ADD_CARRY_IND: timing = `TM_ADD_IND;
      cpu_timing_pkg::ADD_CARRY_IMM: timing = `TM_ADD_IMM;
      cpu_timing_pkg::SUB_BORROW_BANK: timing = `TM_SUB_BORROW_BANK;
      default: timing = `TM_NONE;
    endcase
  end

  assign lenBytes = timing[`TM_LEN_MSB:`TM_LEN_LSB];
  assign cycles = timing[`TM_CYC_MSB:`TM_CYC_LSB];
  assign legal = (cycles != 3'h0);

  assign codeRd = (form == cpu_timing_pkg::CODE_RD_DP) |
                  (form == cpu_timing_pkg::CODE_RD_PC);
  assign pcBase = (form == cpu_timing_pkg::CODE_RD_PC);
  assign auxRd = (form == cpu_timing_pkg::AUX_RD_IND) |
                 (form == cpu_timing_pkg::AUX_RD_DP);
  assign auxWr = (form == cpu_timing_pkg::AUX_WR_IND) |
                 (form == cpu_timing_pkg::AUX_WR_DP);
  assign auxWide = (form == cpu_timing_pkg::AUX_RD_DP) |
                   (form == cpu_timing_pkg::AUX_WR_DP);
  assign pushOp = (form == cpu_timing_pkg::STACK_PUSH);
  assign popOp = (form == cpu_timing_pkg::STACK_POP);
  assign wrAccum = (form inside {[cpu_timing_pkg::ACCUM_FROM_BANK:
                                   cpu_timing_pkg::ACCUM_FROM_IMM]}) |
                   codeRd | auxRd |
                   (form inside {[cpu_timing_pkg::SWAP_BANK:
                                   cpu_timing_pkg::SUB_BORROW_BANK]});
  assign wrData = (form inside {[cpu_timing_pkg::BANK_FROM_ACCUM:
                                  cpu_timing_pkg::DP_LOAD_IMM]}) |
                  pushOp | popOp |
                  (form inside {[cpu_timing_pkg::SWAP_BANK:
                                  cpu_timing_pkg::NIB_SWAP_IND]});

endmodule

// file: verification/cpu_timing_assertions.sv
`timescale 1ns/1ps

module cpu_timing_assertions
#(
  parameter int CYCLE_W = 3
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Requests
  input wire logic clkEn,
  input wire logic formValid,
  input wire cpu_timing_pkg::instr_form_t formCode,
  input wire logic extTarget,
  // Status and strobes
  input wire logic formReady,
  input wire logic busy,
  input wire logic instrDone,
  input wire logic [CYCLE_W-1:0] stepIndex,
  input wire logic [CYCLE_W-1:0] cycleCount,
  input wire logic unsupportedFault,
  input wire logic codeReadEn,
  input wire logic auxWriteEn,
  input wire logic stackPop,
  input wire logic auxReadEn,
  input wire logic stackPush,
  input wire logic accumWriteEn,
  input wire logic dataWriteEn
);
  wire take = clkEn && formValid && formReady;
  wire isAux = formCode >= cpu_timing_pkg::AUX_RD_IND &&
    formCode <= cpu_timing_pkg::AUX_WR_DP;
  wire bad = formCode == cpu_timing_pkg::FORM_NONE || (isAux && extTarget);
  wire ok = take && !bad;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_busy_after_take: assert property (ok |=> busy && stepIndex == 0)
    else $error("busy or step wrong after a legal form");
  a_refuse_ext: assert property (take && bad |=>
    unsupportedFault && !busy)
    else $error("refused form not faulted");
  a_done_at_count: assert property (instrDone |->
    busy && stepIndex == cycleCount - 1)
    else $error("done not in the last counted cycle");
  a_step_advance: assert property (clkEn && busy && !instrDone |=>
    busy && stepIndex == $past(stepIndex) + 1)
    else $error("step did not advance by one");
  a_ready_at_done: assert property (busy |-> formReady == instrDone)
    else $error("ready not matching done while busy");
  a_idle_after_done: assert property (instrDone && clkEn && !take |=>
    !busy)
    else $error("busy past the last cycle");
  a_code_penult: assert property (codeReadEn && clkEn |=> instrDone)
    else $error("code read strobe not penultimate");
  a_aux_rd_penult: assert property (auxReadEn && clkEn |=> instrDone)
    else $error("aux read strobe not penultimate");
  a_push_last: assert property (stackPush |-> instrDone)
    else $error("push strobe not in last cycle");
  a_accum_wr_last: assert property (accumWriteEn |-> instrDone)
    else $error("accumulator write not in last cycle");
  a_data_wr_last: assert property (dataWriteEn |-> instrDone)
    else $error("data write not in last cycle");
  a_aux_wr_last: assert property (auxWriteEn |-> instrDone)
    else $error("aux write strobe not in last cycle");
  a_pop_first: assert property (stackPop |-> busy && stepIndex == 0)
    else $error("pop strobe not in first cycle");

  c_code_pc: cover property (ok && formCode == cpu_timing_pkg::CODE_RD_PC);
  c_b2b: cover property (instrDone && take);
  c_refused: cover property (take && bad);
endmodule

// file: verification/mem_side_model.sv
`timescale 1ns/1ps

module mem_side_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Strobes from the core
  input wire logic codeReadEn,
  input wire logic auxReadEn,
  input wire logic auxWriteEn,
  input wire logic stackPush,
  input wire logic stackPop,
  // Access tallies
  output int codeCount,
  output int auxCount,
  output int pushCount,
  output int popCount
);
  // Tallies only: no data path reaches the core
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      codeCount <= 0;
      auxCount <= 0;
      pushCount <= 0;
      popCount <= 0;
    end
    else
    begin
      codeCount <= codeCount + int'(codeReadEn);
      auxCount <= auxCount + int'(auxReadEn) + int'(auxWriteEn);
      pushCount <= pushCount + int'(stackPush);
      popCount <= popCount + int'(stackPop);
    end
  end
endmodule

// file: verification/cpu_instruction_length_timing_tb_top.sv
`timescale 1ns/1ps

module cpu_instruction_length_timing_tb_top;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic clkEn = 1'h1;
  logic formValid = 1'h0;
  cpu_timing_pkg::instr_form_t formCode = cpu_timing_pkg::FORM_NONE;
  logic extTarget = 1'h0;
  logic [7:0] accumulator = 8'h00;
  logic [15:0] dataPointer = 16'h0000;
  logic [15:0] progCounter = 16'h0000;
  logic formReady, busy, instrDone, unsupportedFault, codeReadEn;
  logic auxReadEn, auxWriteEn, auxAddrWide, stackPush, stackPop;
  logic accumWriteEn, dataWriteEn;
  logic [2:0] stepIndex, cycleCount;
  logic [1:0] instrLength;
  logic [15:0] codeReadAddr;
  int codeCount, auxCount, pushCount, popCount;
  int n_fail = 0;
  int num_checks = 0;

  always #2 clk_sys = ~clk_sys;

  cpu_instruction_length_timing u_cpu_instruction_length_timing (
    .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .formValid(formValid),
    .formCode(formCode), .extTarget(extTarget),
    .accumulator(accumulator), .dataPointer(dataPointer),
    .progCounter(progCounter), .formReady(formReady), .busy(busy),
    .instrDone(instrDone), .stepIndex(stepIndex),
    .instrLength(instrLength), .cycleCount(cycleCount),
    .unsupportedFault(unsupportedFault), .codeReadEn(codeReadEn),
    .codeReadAddr(codeReadAddr), .auxReadEn(auxReadEn),
    .auxWriteEn(auxWriteEn), .auxAddrWide(auxAddrWide),
    .stackPush(stackPush), .stackPop(stackPop),
    .accumWriteEn(accumWriteEn), .dataWriteEn(dataWriteEn));

  mem_side_model u_mem_side_model (
    .clk_sys(clk_sys), .rst(rst), .codeReadEn(codeReadEn),
    .auxReadEn(auxReadEn), .auxWriteEn(auxWriteEn),
    .stackPush(stackPush), .stackPop(stackPop), .codeCount(codeCount),
    .auxCount(auxCount), .pushCount(pushCount), .popCount(popCount));

  // Length above, cycles below, per form
  function automatic logic [4:0] expTiming(cpu_timing_pkg::instr_form_t f);
    case (f)
      cpu_timing_pkg::ACCUM_FROM_BANK: return {2'h1, 3'h1};
      cpu_timing_pkg::ACCUM_FROM_DIR, cpu_timing_pkg::ACCUM_FROM_IMM,
      cpu_timing_pkg::BANK_FROM_IMM, cpu_timing_pkg::ADD_IMM,
      cpu_timing_pkg::ADD_CARRY_IMM: return {2'h2, 3'h2};
      cpu_timing_pkg::ACCUM_FROM_IND, cpu_timing_pkg::BANK_FROM_ACCUM,
      cpu_timing_pkg::ADD_BANK, cpu_timing_pkg::ADD_CARRY_BANK,
      cpu_timing_pkg::SUB_BORROW_BANK: return {2'h1, 3'h2};
      cpu_timing_pkg::BANK_FROM_DIR, cpu_timing_pkg::DIR_FROM_IND,
      cpu_timing_pkg::STACK_PUSH, cpu_timing_pkg::SWAP_DIR:
        return {2'h2, 3'h4};
      cpu_timing_pkg::DIR_FROM_DIR: return {2'h3, 3'h4};
      cpu_timing_pkg::DIR_FROM_IMM, cpu_timing_pkg::DP_LOAD_IMM:
        return {2'h3, 3'h3};
      cpu_timing_pkg::CODE_RD_DP, cpu_timing_pkg::CODE_RD_PC,
      cpu_timing_pkg::SWAP_IND, cpu_timing_pkg::NIB_SWAP_IND:
        return {2'h1, 3'h4};
      cpu_timing_pkg::DIR_FROM_ACCUM, cpu_timing_pkg::DIR_FROM_BANK,
      cpu_timing_pkg::IND_FROM_DIR, cpu_timing_pkg::IND_FROM_IMM,
      cpu_timing_pkg::STACK_POP, cpu_timing_pkg::ADD_DIR,
      cpu_timing_pkg::ADD_CARRY_DIR: return {2'h2, 3'h3};
      cpu_timing_pkg::FORM_NONE: return 5'h00;
      default: return {2'h1, 3'h3};
    endcase
  endfunction

  task automatic summarize;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task automatic check(input string nm, input logic [15:0] exp,
    input logic [15:0] got);
    begin
      num_checks++;
      if (got !== exp)
      begin
        n_fail++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // One form from idle; n counts busy cycles, flt the fault pulse
  task automatic run(input cpu_timing_pkg::instr_form_t f, input logic ext,
    output int n, output logic flt);
    begin
      @(negedge clk_sys);
      formValid = 1'h1;
      formCode = f;
      extTarget = ext;
      @(negedge clk_sys);
      formValid = 1'h0;
      flt = unsupportedFault;
      n = 0;
      while (busy === 1'h1 && n < 8)
      begin
        n++;
        @(negedge clk_sys);
      end
      if (n >= 8)
      begin
        n_fail++;
        summarize();
      end
    end
  endtask

  task automatic t_all_forms;
    int n;
    logic flt;
    logic [4:0] e;
    cpu_timing_pkg::instr_form_t f;
    begin
      for (int i = 1; i <= 37; i++)
      begin
        f = cpu_timing_pkg::instr_form_t'(i[5:0]);
        e = expTiming(f);
        run(f, 1'h0, n, flt);
        check(f.name(), e[4:3], instrLength);
        check(f.name(), e[2:0], cycleCount);
        check(f.name(), e[2:0], n[15:0]);
      end
      $display("t_all_forms done");
    end
  endtask

  task automatic t_back_to_back;
    int n;
    begin
      @(negedge clk_sys);
      formValid = 1'h1;
      formCode = cpu_timing_pkg::DIR_FROM_DIR;
      @(negedge clk_sys);
      n = 1;
      while (instrDone !== 1'h1 && n < 8)
      begin
        n++;
        @(negedge clk_sys);
      end
      if (instrDone !== 1'h1)
      begin
        n_fail++;
        summarize();
      end
      formCode = cpu_timing_pkg::ADD_IND;
      @(negedge clk_sys);
      formValid = 1'h0;
      while (busy === 1'h1 && n < 16)
      begin
        n++;
        @(negedge clk_sys);
      end
      check("b2b cycles", 16'h0007, n[15:0]);
      $display("t_back_to_back done");
    end
  endtask

  task automatic t_code_read;
    int n, c0;
    logic flt;
    begin
      c0 = codeCount;
      accumulator = 8'h10;
      dataPointer = 16'hfff8;
      progCounter = 16'h0234;
      run(cpu_timing_pkg::CODE_RD_DP, 1'h0, n, flt);
      check("addr dp", 16'h0008, codeReadAddr);
      accumulator = 8'hf0;
      run(cpu_timing_pkg::CODE_RD_PC, 1'h0, n, flt);
      check("addr pc", 16'h0324, codeReadAddr);
      check("code reads", 16'h0002, 16'(codeCount - c0));
      $display("t_code_read done");
    end
  endtask

  task automatic t_aux_and_refuse;
    int n, a0;
    logic flt;
    cpu_timing_pkg::instr_form_t f;
    begin
      a0 = auxCount;
      for (int i = 19; i <= 22; i++)
      begin
        f = cpu_timing_pkg::instr_form_t'(i[5:0]);
        run(f, 1'h1, n, flt);
        check("ext busy", 16'h0000, n[15:0]);
        check("ext fault", 16'h0001, flt);
        run(f, 1'h0, n, flt);
        check("aux wide", 16'(i == 20 || i == 22), auxAddrWide);
      end
      check("aux strobes", 16'h0004, 16'(auxCount - a0));
      run(cpu_timing_pkg::FORM_NONE, 1'h0, n, flt);
      check("none fault", 16'h0001, flt);
      $display("t_aux_and_refuse done");
    end
  endtask

  task automatic t_stack;
    int n, p0, q0;
    logic flt;
    begin
      p0 = pushCount;
      q0 = popCount;
      run(cpu_timing_pkg::STACK_PUSH, 1'h0, n, flt);
      run(cpu_timing_pkg::STACK_POP, 1'h0, n, flt);
      check("push", 16'h0001, 16'(pushCount - p0));
      check("pop", 16'h0001, 16'(popCount - q0));
      $display("t_stack done");
    end
  endtask

  // Enable low mid-instruction must stretch, not shorten, the count
  task automatic t_clock_hold;
    int n;
    begin
      @(negedge clk_sys);
      formValid = 1'h1;
      formCode = cpu_timing_pkg::DIR_FROM_ACCUM;
      @(negedge clk_sys);
      formValid = 1'h0;
      clkEn = 1'h0;
      repeat (3) @(negedge clk_sys);
      check("hold busy", 16'h0001, busy);
      check("hold step", 16'h0000, stepIndex);
      clkEn = 1'h1;
      n = 0;
      while (busy === 1'h1 && n < 8)
      begin
        n++;
        @(negedge clk_sys);
      end
      check("hold cycles", 16'h0003, n[15:0]);
      $display("t_clock_hold done");
    end
  endtask

  initial
  begin
    repeat (16) @(negedge clk_sys);
    rst = 1'h0;
    t_all_forms();
    t_back_to_back();
    t_code_read();
    t_aux_and_refuse();
    t_stack();
    t_clock_hold();
    summarize();
  end
endmodule

bind cpu_instruction_length_timing cpu_timing_assertions
  #(.CYCLE_W(CYCLE_W)) u_cpu_timing_assertions (
  .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .formValid(formValid),
  .formCode(formCode), .extTarget(extTarget), .formReady(formReady),
  .busy(busy), .instrDone(instrDone), .stepIndex(stepIndex),
  .cycleCount(cycleCount), .unsupportedFault(unsupportedFault),
  .codeReadEn(codeReadEn), .auxWriteEn(auxWriteEn), .stackPop(stackPop),
  .auxReadEn(auxReadEn), .stackPush(stackPush),
  .accumWriteEn(accumWriteEn), .dataWriteEn(dataWriteEn));
